/* eeprom_data_access_ctrl.sv */
// Data EEPROM access controller: index, value and control registers.
// Assumes the CPU decodes direct and indirect accesses into the strobes.
`timescale 1ns/1ps
`include "nvm_map.svh"
module eeprom_data_access_ctrl
	import nvm_pkg::*;
#(
	parameter int DEPTH = 64,
	parameter int AW    = 6
) (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       slow_clk,
	input  wire logic       index_wr,
	input  wire logic       value_wr,
	input  wire logic       ptr_wr,
	input  wire logic       ptr_rd,
	input  wire logic [7:0] ptr_low,
	input  wire logic [7:0] ptr_high,
	input  wire logic [7:0] wdata,
	input  wire logic       global_irq_enable,
	input  wire logic       nvm_done_irq_enable,
	input  wire logic       stack_full,
	input  wire logic       irq_serviced,
	output logic [7:0]      nvm_byte_index,
	output logic [7:0]      nvm_byte_value,
	output logic [7:0]      nvm_control,
	output logic [7:0]      indirect_rdata,
	output logic            nvm_done_pending,
	output logic            irq_request
);
	logic [AW-1:0] index;
	logic [7:0]    value;
	logic          program_permit;
	logic          program_go;
	logic          fetch_permit;
	logic          fetch_go;
	cycle_e        state;
	logic [3:0]    fetch_count;
	logic [7:0]    tick_count;
	logic          tick;
	logic          ctl_hit;
	logic          start_fetch;
	logic          start_program;
	logic          program_done;
	logic          fetch_done;
	logic          array_wr;
	logic [7:0]    array_rd;

	nvm_tick_sync nvm_tick_sync_inst (
		.core_clk (core_clk),
		.rst      (rst),
		.slow_clk (slow_clk),
		.tick     (tick)
	);

	nvm_array #(.DEPTH(DEPTH), .AW(AW)) nvm_array_inst (
		.core_clk (core_clk),
		.wr_en    (array_wr),
		.addr     (index),
		.wr_data  (value),
		.rd_data  (array_rd)
	);

	// Only pointer 01H:3EH reaches the control register
	assign ctl_hit = (ptr_low == `NVM_CONTROL_OFFSET) &&
		(ptr_high == `NVM_CONTROL_SECTOR);

	// Go bits count only with permit already held before this write
	assign start_fetch = ctl_hit && ptr_wr && (state == idle_st) &&
		wdata[`CTL_FETCH_GO] && fetch_permit;
	assign start_program = ctl_hit && ptr_wr && (state == idle_st) &&
		wdata[`CTL_PROGRAM_GO] && program_permit &&
		!start_fetch;

	assign fetch_done = (state == fetch_st) &&
		(fetch_count == `FETCH_CYCLES);
	// Write length is set by slow timer ticks, not core cycles
	assign program_done = (state == program_st) && tick &&
		(tick_count == `PROGRAM_TICKS);
	// Commit at end of cycle; permit still gates it
	assign array_wr = program_done && program_permit;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state <= idle_st;
		end else begin
			case (state)
				idle_st: begin
					if (start_fetch) begin
						state <= fetch_st;
					end else if (start_program) begin
						state <= program_st;
					end
				end
				fetch_st: begin
					if (fetch_done) begin
						state <= idle_st;
					end
				end
				program_st: begin
					if (program_done) begin
						state <= idle_st;
					end
				end
				default: state <= idle_st;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst || state != fetch_st) begin
			fetch_count <= 4'h0;
		end else begin
			fetch_count <= fetch_count + 4'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst || state != program_st) begin
			tick_count <= 8'h00;
		end else if (tick) begin
			tick_count <= tick_count + 8'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			index <= `INDEX_RESET;
		end else if (index_wr) begin
			index <= wdata[AW-1:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			value <= `VALUE_RESET;
		end else if (fetch_done) begin
			value <= array_rd;
		end else if (value_wr) begin
			value <= wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			program_permit <= 1'b0;
		end else if (ctl_hit && ptr_wr) begin
			program_permit <= wdata[`CTL_PROGRAM_PERMIT];
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			fetch_permit <= 1'b0;
		end else if (ctl_hit && ptr_wr) begin
			fetch_permit <= wdata[`CTL_FETCH_PERMIT];
		end
	end

	// Go bits read back as busy; software writes of zero are ignored
	always_ff @(posedge core_clk) begin
		if (rst) begin
			fetch_go <= 1'b0;
		end else if (start_fetch) begin
			fetch_go <= 1'b1;
		end else if (fetch_done) begin
			fetch_go <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			program_go <= 1'b0;
		end else if (start_program) begin
			program_go <= 1'b1;
		end else if (program_done) begin
			program_go <= 1'b0;
		end
	end

	// Set wins over the service clear
	always_ff @(posedge core_clk) begin
		if (rst) begin
			nvm_done_pending <= 1'b0;
		end else if (program_done) begin
			nvm_done_pending <= 1'b1;
		end else if (irq_serviced) begin
			nvm_done_pending <= 1'b0;
		end
	end

	assign irq_request = nvm_done_pending && nvm_done_irq_enable &&
		global_irq_enable && !stack_full;

	assign nvm_byte_index = {{(8 - AW){1'b0}}, index};
	assign nvm_byte_value = value;
	assign nvm_control = {4'h0, program_permit, program_go,
		fetch_permit, fetch_go};

	always_ff @(posedge core_clk) begin
		if (rst) begin
			indirect_rdata <= 8'h00;
		end else if (ptr_rd && ctl_hit) begin
			indirect_rdata <= nvm_control;
		end else if (ptr_rd) begin
			indirect_rdata <= 8'h00;
		end
	end
endmodule

/* nvm_map.svh */
// Constants for the data EEPROM access controller.
// Assumes inclusion by bare name from the same folder.
// Notes on behaviour
// - Store holds sixty-four locations of eight bits, one byte per access.
// - Byte index has six read/write low bits; top two read as zero.
// - Byte value register, eight bits, resets to zero, carries write and read data.
// - Control bits: program permit 3, program go 2, fetch permit 1, fetch go 0.
// - Program permit low blocks every write to the store.
// - Program go starts a write only if program permit is already set.
// - Program go clears itself when the write cycle completes.
// - Fetch permit low blocks reads; fetch go alone starts nothing.
// - Read completion loads the byte value and clears fetch go on the same clock edge.
// - Byte value keeps a read result until the next read or write.
// - Write duration set by a timer asynchronous to the system clock.
// - Program permit is clear after power-on.
// - Write end sets done pending; vector when enabled and stack not full.
// - Done pending clears when its interrupt is serviced.
`ifndef NVM_MAP_SVH
`define NVM_MAP_SVH
`define NVM_CONTROL_OFFSET 8'h3e
`define NVM_CONTROL_SECTOR 8'h01
`define CTL_PROGRAM_PERMIT 3
`define CTL_PROGRAM_GO 2
`define CTL_FETCH_PERMIT 1
`define CTL_FETCH_GO 0
`define INDEX_RESET 6'h00
`define VALUE_RESET 8'h00
`define CONTROL_RESET 4'h0
`define FETCH_CYCLES 4'h2
`define PROGRAM_TICKS 8'h40
`endif

/* nvm_pkg.sv */
// Types shared by the data EEPROM access controller.
// Assumes the map header supplies all numbers.
package nvm_pkg;
	typedef enum logic [1:0] {idle_st, fetch_st, program_st} cycle_e;
endpackage

/* nvm_array.sv */
// Byte-wide storage array for the data EEPROM.
// Assumes one access per cycle from the controller.
`timescale 1ns/1ps
module nvm_array #(
	parameter int DEPTH = 64,
	parameter int AW    = 6
) (
	input  wire logic          core_clk,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] addr,
	input  wire logic [7:0]    wr_data,
	output logic      [7:0]    rd_data
);
	// Nonvolatile content is not cleared by reset
	logic [7:0] cells [DEPTH];

	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			cells[addr] <= wr_data;
		end
	end

	always_ff @(posedge core_clk) begin
		rd_data <= cells[addr];
	end
endmodule

/* nvm_tick_sync.sv */
// Brings the write timer's slow clock into the core domain as a pulse.
// Assumes slow_clk is a free running clock from another domain.
`timescale 1ns/1ps
module nvm_tick_sync (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic slow_clk,
	output logic      tick
);
	logic meta;
	logic stable;
	logic last;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta   <= 1'b0;
			stable <= 1'b0;
			last   <= 1'b0;
		end else begin
			meta   <= slow_clk;
			stable <= meta;
			last   <= stable;
		end
	end

	assign tick = stable & ~last;
endmodule

/* nvm_cpu.sv */
// CPU side model: drives the register strobes as software would.
// Assumes strobes are sampled on the rising edge of core_clk.
`timescale 1ns/1ps
module nvm_cpu (
	input  wire logic       core_clk,
	output logic            index_wr,
	output logic            value_wr,
	output logic            ptr_wr,
	output logic [7:0]      ptr_low,
	output logic [7:0]      ptr_high,
	output logic [7:0]      wdata
);
	initial begin
		{index_wr, value_wr, ptr_wr, wdata} = '0;
		ptr_low = 8'h3e;
		ptr_high = 8'h01;
	end
	// Strobe stays up until idle, so two puts land in consecutive cycles
	task put(input int k, input logic [7:0] d);
		@(negedge core_clk);
		wdata = d;
		{index_wr, value_wr, ptr_wr} = {k == 0, k == 1, k == 2};
	endtask
	task point(input logic [7:0] lo, input logic [7:0] hi);
		@(negedge core_clk);
		ptr_low = lo;
		ptr_high = hi;
	endtask
	task idle();
		@(negedge core_clk);
		{index_wr, value_wr, ptr_wr} = '0;
	endtask
endmodule

/* eeprom_data_access_ctrl_sva.sv */
// Checker for the data EEPROM controller ports.
// Assumes one core_clk domain and a synchronous active-high rst.
`timescale 1ns/1ps
`include "nvm_map.svh"
module eeprom_data_access_ctrl_sva (
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic       value_wr,
	input wire logic       irq_serviced,
	input wire logic       ptr_rd,
	input wire logic [7:0] ptr_low,
	input wire logic [7:0] ptr_high,
	input wire logic [7:0] indirect_rdata,
	input wire logic       global_irq_enable,
	input wire logic       nvm_done_irq_enable,
	input wire logic       stack_full,
	input wire logic       irq_request,
	input wire logic [7:0] nvm_byte_index,
	input wire logic [7:0] nvm_byte_value,
	input wire logic [7:0] nvm_control,
	input wire logic       nvm_done_pending
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	wire fgo = nvm_control[0];
	wire wgo = nvm_control[2];
	wire ctl_ptr = ptr_low == `NVM_CONTROL_OFFSET &&
		ptr_high == `NVM_CONTROL_SECTOR;
	a_upper_zero: assert property
		(nvm_control[7:4] == 4'h0 && nvm_byte_index[7:6] == 2'h0)
		else $error("upper bits set");
	a_prog_permit: assert property
		($rose(wgo) |-> $past(nvm_control[3])) else $error("write no permit");
	a_fetch_permit: assert property
		($rose(fgo) |-> $past(nvm_control[1])) else $error("read no permit");
	a_fetch_len: assert property
		($rose(fgo) |-> fgo [*3] ##1 !fgo) else $error("read length");
	a_value_hold: assert property
		($changed(nvm_byte_value) |-> $past(value_wr) || $fell(fgo))
		else $error("value changed");
	a_done_sets: assert property
		($fell(wgo) |-> nvm_done_pending) else $error("no pending");
	a_pend_cause: assert property
		($rose(nvm_done_pending) |-> $fell(wgo)) else $error("stray pending");
	a_serv_clear: assert property
		($past(irq_serviced) && !$fell(wgo) |-> !nvm_done_pending)
		else $error("pending kept");
	a_busy_ignore: assert property
		($rose(fgo) |-> !$past(wgo)) else $error("start while busy");
	a_ind_read: assert property
		($past(ptr_rd) |-> indirect_rdata ==
			($past(ctl_ptr) ? $past(nvm_control) : 8'h00))
		else $error("indirect read data");
	a_irq_gate: assert property
		(irq_request == (nvm_done_pending && nvm_done_irq_enable &&
			global_irq_enable && !stack_full)) else $error("irq gate");
	cover property ($fell(fgo));
	cover property (irq_request);
	cover property ($fell(wgo));
	cover property ($fell(nvm_done_pending));
endmodule

/* eeprom_data_access_ctrl_tb.sv */
// Self-checking bench for the data EEPROM access controller.
// Assumes nvm_cpu drives the strobes; slow_clk runs free.
`timescale 1ns/1ps
module eeprom_data_access_ctrl_tb;
	logic       core_clk, rst, slow_clk, ptr_rd, irq_serviced, stack_full;
	logic       global_irq_enable, nvm_done_irq_enable;
	logic       index_wr, value_wr, ptr_wr, nvm_done_pending, irq_request;
	logic [7:0] ptr_low, ptr_high, wdata, indirect_rdata;
	logic [7:0] nvm_byte_index, nvm_byte_value, nvm_control;
	int         fail_count, cmp_count, n;
	nvm_cpu nvm_cpu_inst (.core_clk, .index_wr, .value_wr, .ptr_wr,
		.ptr_low, .ptr_high, .wdata);
	eeprom_data_access_ctrl eeprom_data_access_ctrl_inst (.core_clk, .rst,
		.slow_clk, .index_wr, .value_wr, .ptr_wr, .ptr_rd, .ptr_low,
		.ptr_high, .wdata, .global_irq_enable, .nvm_done_irq_enable,
		.stack_full, .irq_serviced, .nvm_byte_index, .nvm_byte_value,
		.nvm_control, .indirect_rdata, .nvm_done_pending, .irq_request);
	initial begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	// Odd half period keeps the timer clock out of phase with core_clk
	initial begin
		slow_clk = 0;
		forever #17 slow_clk = ~slow_clk;
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task final_report();
		$display("Checks %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task wait_go(input int b);
		n = 0;
		while (nvm_control[b] !== 1'b0 && n < 400) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 400) begin
			fail_count++;
			$display("Error at %0t: go bit stuck", $time);
		end
	endtask
	task t_regs();
		nvm_cpu_inst.put(0, 8'hff);
		nvm_cpu_inst.put(1, 8'ha5);
		nvm_cpu_inst.put(2, 8'h05);
		nvm_cpu_inst.idle();
		chk(nvm_byte_index, 8'h3f);
		chk(nvm_byte_value, 8'ha5);
		chk(nvm_control, 8'h00);
	endtask
	task t_write();
		global_irq_enable = 0;
		nvm_cpu_inst.put(0, 8'h05);
		nvm_cpu_inst.put(1, 8'h3c);
		nvm_cpu_inst.put(2, 8'h08);
		nvm_cpu_inst.put(2, 8'h0c);
		nvm_cpu_inst.idle();
		global_irq_enable = 1;
		chk(nvm_control, 8'h0c);
		wait_go(2);
		chk(nvm_control, 8'h08);
		chk({7'h0, irq_request}, 8'h01);
		stack_full = 1;
		@(negedge core_clk);
		chk({7'h0, irq_request}, 8'h00);
		stack_full = 0;
		nvm_done_irq_enable = 0;
		@(negedge core_clk);
		chk({7'h0, irq_request}, 8'h00);
		nvm_done_irq_enable = 1;
		irq_serviced = 1;
		@(negedge core_clk);
		irq_serviced = 0;
		chk({7'h0, nvm_done_pending}, 8'h00);
		chk({7'h0, irq_request}, 8'h00);
	endtask
	task t_read();
		nvm_cpu_inst.put(1, 8'h00);
		nvm_cpu_inst.put(2, 8'h02);
		nvm_cpu_inst.put(2, 8'h03);
		nvm_cpu_inst.put(2, 8'h03);
		nvm_cpu_inst.idle();
		wait_go(0);
		chk(n[7:0], 8'h02);
		chk(nvm_byte_value, 8'h3c);
		repeat (3) @(negedge core_clk);
		chk(nvm_byte_value, 8'h3c);
	endtask
	// Pointer other than the control slot must neither read nor write it
	task t_ind();
		ptr_rd = 1;
		@(negedge core_clk);
		ptr_rd = 0;
		chk(indirect_rdata, 8'h02);
		nvm_cpu_inst.point(8'h3d, 8'h01);
		ptr_rd = 1;
		nvm_cpu_inst.put(2, 8'h0a);
		ptr_rd = 0;
		nvm_cpu_inst.idle();
		chk(indirect_rdata, 8'h00);
		chk(nvm_control, 8'h02);
		nvm_cpu_inst.point(8'h3e, 8'h01);
	endtask
	initial begin
		{ptr_rd, irq_serviced, stack_full} = '0;
		{rst, global_irq_enable, nvm_done_irq_enable} = '1;
		{fail_count, cmp_count} = '0;
		repeat (5) @(negedge core_clk);
		rst = 0;
		chk(nvm_control, 8'h00);
		chk(nvm_byte_value, 8'h00);
		t_regs();
		t_write();
		t_read();
		t_ind();
		final_report();
	end
	initial begin
		#100000;
		fail_count++;
		$display("Error at %0t: timeout", $time);
		final_report();
	end
endmodule
bind eeprom_data_access_ctrl eeprom_data_access_ctrl_sva sva_inst (
	.core_clk, .rst, .value_wr, .irq_serviced, .ptr_rd, .ptr_low,
	.ptr_high, .indirect_rdata, .global_irq_enable, .nvm_done_irq_enable,
	.stack_full, .irq_request, .nvm_byte_index,
	.nvm_byte_value, .nvm_control, .nvm_done_pending);
